/* File: verilog/arc_input_cond.sv */
// Analog reference input conditioning: voltage and universal input scaling,
// smoothing, use distribution and live-zero loss supervision.
// Assumes converter samples are synchronous and arrive on one strobe.
//
// Summary of operation
// - Each input has a use select: none, fref1, fref2, correction, PID set/feedback, request.
// - A use already taken by one input is refused to the other, setting a status bit.
// - Voltage range code 1 is unipolar, code 2 bipolar; unipolar after reset.
// - Voltage input maps linearly from low point at range bottom to high point at +10 V.
// - Universal input maps from low point at 0 V/0 mA/4 mA to high point at full scale.
// - Scaled output is in Hz for frequency uses, percent for all others.
// - Universal range code 1 is 0-10 V, 3 is 0-20 mA, 4 is 4-20 mA (default).
// - Loss supervision works only while the 4-20 mA range is selected.
// - Reference loss is declared when current falls below 2 mA under supervision.
// - Loss with reaction 1 trips the drive.
// - Loss with reaction 2 raises alarm and holds the last valid reference.
// - Loss with reaction 3 raises alarm and substitutes the emergency reference.
// - Loss reaction is set per supervised source.
// - Each input has a smoothing time; universal up to 30 s, default 0.1 s.
// - Smoothing time zero passes the scaled value straight through.
// - Universal input use defaults to frequency reference one after reset.
// - Multiplicative correction is a percent factor, 100 % meaning factor one.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module arc_input_cond #(
  parameter int SAMPLE_US = 1000
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset,
  input  wire logic [arc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [arc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [arc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic signed [15:0]        i_voltage_sample,
  input  wire logic signed [15:0]        i_universal_sample,
  input  wire logic                      i_sample_strobe,
  input  wire logic                      i_correction_multiplicative,
  output logic [arc_pkg::NUM_USES-1:0][15:0] o_use_value,
  output logic [arc_pkg::NUM_USES-1:0]   o_use_valid,
  output logic                           o_voltage_unit_hz,
  output logic                           o_universal_unit_hz,
  output logic                           o_ref_loss,
  output logic                           o_alarm,
  output logic                           o_trip,
  output logic                           o_irq
);
  // Samples per 0.1 s of smoothing time
  localparam int TENTH_S_US = 100000;
  localparam int TENTH_SAMPLES = TENTH_S_US / SAMPLE_US;
  localparam logic [3:0] USE_CODES [arc_pkg::NUM_USES] = '{arc_pkg::USE_FREF1, arc_pkg::USE_FREF2,
    arc_pkg::USE_FCORR, arc_pkg::USE_PIDSET, arc_pkg::USE_PIDFB, arc_pkg::USE_REQ};

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [3:0]  use_sel   [2];
  logic [2:0]  range_sel [2];
  logic [15:0] low_pt    [2];
  logic [15:0] high_pt   [2];
  logic [15:0] smooth    [2];
  logic [1:0]  loss_react;
  logic [15:0] emerg_val;
  logic [arc_pkg::ST_W-1:0] status;
  logic [arc_pkg::ST_W-1:0] mask;
  logic        trip_latch;
  logic        loss;
  logic signed [31:0] acc [2];

  function automatic logic use_legal(input logic [3:0] u);
    return u inside {arc_pkg::USE_NONE, arc_pkg::USE_FREF1, arc_pkg::USE_FREF2, arc_pkg::USE_FCORR,
                     arc_pkg::USE_PIDSET, arc_pkg::USE_PIDFB, arc_pkg::USE_REQ};
  endfunction

  logic [3:0]  wr_use;
  logic [15:0] wr_smooth;
  logic        wr_vcfg;
  logic        wr_ucfg;
  logic        conflict;
  assign wr_use    = i_wdata[arc_pkg::USE_LSB +: 4];
  assign wr_smooth = (i_wdata[15:0] > arc_pkg::SMOOTH_MAX) ? arc_pkg::SMOOTH_MAX : i_wdata[15:0];
  assign wr_vcfg   = i_wr && (i_addr == arc_pkg::ADDR_VOLT_CFG);
  assign wr_ucfg   = i_wr && (i_addr == arc_pkg::ADDR_UNIV_CFG);
  // A use held by the other input cannot be granted twice
  assign conflict  = (wr_use != arc_pkg::USE_NONE) &&
                     ((wr_vcfg && use_sel[1] == wr_use) || (wr_ucfg && use_sel[0] == wr_use));

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      use_sel[0]   <= arc_pkg::USE_NONE;
      use_sel[1]   <= arc_pkg::USE_FREF1;
      range_sel[0] <= arc_pkg::RANGE_0_10V;
      range_sel[1] <= arc_pkg::RANGE_4_20MA;
      loss_react   <= arc_pkg::REACT_TRIP;
    end else begin
      if (wr_vcfg) begin
        if (use_legal(wr_use) && !conflict) begin
          use_sel[0] <= wr_use;
        end
        if (i_wdata[arc_pkg::RANGE_LSB +: 3] inside {arc_pkg::RANGE_0_10V, arc_pkg::RANGE_PM10V}) begin
          range_sel[0] <= i_wdata[arc_pkg::RANGE_LSB +: 3];
        end
      end
      if (wr_ucfg) begin
        if (use_legal(wr_use) && !conflict) begin
          use_sel[1] <= wr_use;
        end
        if (i_wdata[arc_pkg::RANGE_LSB +: 3] inside
            {arc_pkg::RANGE_0_10V, arc_pkg::RANGE_0_20MA, arc_pkg::RANGE_4_20MA}) begin
          range_sel[1] <= i_wdata[arc_pkg::RANGE_LSB +: 3];
        end
        if (i_wdata[arc_pkg::REACT_LSB +: 2] != 2'h0) begin
          loss_react <= i_wdata[arc_pkg::REACT_LSB +: 2];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      low_pt[0]  <= '0;
      low_pt[1]  <= '0;
      high_pt[0] <= arc_pkg::HIGH_RESET;
      high_pt[1] <= arc_pkg::HIGH_RESET;
      smooth[0]  <= arc_pkg::SMOOTH_RESET;
      smooth[1]  <= arc_pkg::SMOOTH_RESET;
      emerg_val  <= '0;
      mask       <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        arc_pkg::ADDR_VOLT_LOW:    low_pt[0]  <= i_wdata[15:0];
        arc_pkg::ADDR_VOLT_HIGH:   high_pt[0] <= i_wdata[15:0];
        arc_pkg::ADDR_VOLT_SMOOTH: smooth[0]  <= wr_smooth;
        arc_pkg::ADDR_UNIV_LOW:    low_pt[1]  <= i_wdata[15:0];
        arc_pkg::ADDR_UNIV_HIGH:   high_pt[1] <= i_wdata[15:0];
        arc_pkg::ADDR_UNIV_SMOOTH: smooth[1]  <= wr_smooth;
        arc_pkg::ADDR_EMERG:       emerg_val  <= i_wdata[15:0];
        arc_pkg::ADDR_MASK:        mask       <= i_wdata[arc_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loss supervision on the universal input
  logic live_zero;
  logic loss_now;
  assign live_zero = (range_sel[1] == arc_pkg::RANGE_4_20MA);
  assign loss_now  = live_zero && ($signed({i_universal_sample[15], i_universal_sample}) < arc_pkg::LOSS_CODE);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      loss <= 1'b0;
    end else if (!live_zero) begin
      loss <= 1'b0;
    end else if (i_sample_strobe) begin
      loss <= loss_now;
    end
  end

  // Trip stays latched until acknowledged with the loss gone
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      trip_latch <= 1'b0;
    end else if (loss && loss_react == arc_pkg::REACT_TRIP) begin
      trip_latch <= 1'b1;
    end else if (i_wr && i_addr == arc_pkg::ADDR_FAULT_ACK) begin
      trip_latch <= 1'b0;
    end
  end

  assign o_ref_loss = loss;
  assign o_trip     = trip_latch;
  assign o_alarm    = loss && (loss_react == arc_pkg::REACT_HOLD || loss_react == arc_pkg::REACT_EMERG);

  //////////////////////////////////////////////////////////////////////////////
  // Scaling and smoothing, one pass per input
  logic signed [16:0] sample [2];
  logic hold_ref;
  assign sample[0] = {i_voltage_sample[15], i_voltage_sample};
  assign sample[1] = {i_universal_sample[15], i_universal_sample};
  // Hold also covers trip so the value does not chase a broken loop.
  // Judged on the sample itself, so a lost sample never enters the filter.
  assign hold_ref  = loss_now && loss_react != arc_pkg::REACT_EMERG;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [16:0] xmin;
    logic signed [17:0] span;
    logic signed [17:0] xoff;
    logic signed [16:0] xc;
    logic signed [16:0] dval;
    logic signed [35:0] num;
    logic signed [15:0] scaled;
    logic signed [15:0] feed;
    logic signed [32:0] diff;
    logic signed [24:0] div_n;
    logic signed [32:0] step;
    logic               upd;

    always_comb begin
      if (ch == 0 && range_sel[0] == arc_pkg::RANGE_PM10V) begin
        xmin = -arc_pkg::FULL_CODE;
      end else if (ch == 1 && range_sel[1] == arc_pkg::RANGE_4_20MA) begin
        xmin = arc_pkg::ZERO4_CODE;
      end else begin
        xmin = '0;
      end
    end

    // Clamp to the range so out-of-range inputs saturate at the end points
    assign xc     = (sample[ch] < xmin) ? xmin : (sample[ch] > arc_pkg::FULL_CODE) ? arc_pkg::FULL_CODE : sample[ch];
    assign span   = 18'(arc_pkg::FULL_CODE) - 18'(xmin);
    assign xoff   = 18'(xc) - 18'(xmin);
    assign dval   = 17'($signed(high_pt[ch])) - 17'($signed(low_pt[ch]));
    assign num    = 36'(dval) * 36'(xoff);
    // Exact division: xoff equal to span gives exactly the high point
    assign scaled = 16'($signed(low_pt[ch]) + 36'(num / 36'(span)));
    assign feed   = (ch == 1 && loss_now && loss_react == arc_pkg::REACT_EMERG) ? $signed(emerg_val) : scaled;
    assign upd    = i_sample_strobe && !(ch == 1 && hold_ref);

    assign diff  = 33'($signed({feed, {arc_pkg::FRAC_W{1'b0}}})) - 33'(acc[ch]);
    assign div_n = 25'(smooth[ch]) * 25'(TENTH_SAMPLES);
    assign step  = diff / 33'(div_n);

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
        acc[ch] <= '0;
      end else if (upd) begin
        if (smooth[ch] == 16'h0000 || div_n == 25'sh0000001) begin
          acc[ch] <= {feed, {arc_pkg::FRAC_W{1'b0}}};
        end else begin
          acc[ch] <= 32'(33'(acc[ch]) + step);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Units and use distribution
  function automatic logic unit_hz(input logic [3:0] u, input logic mult);
    // Multiplicative correction is a percent factor: 1000 counts mean factor one
    if (u == arc_pkg::USE_FCORR && mult) begin
      return 1'b0;
    end
    return u inside {arc_pkg::USE_FREF1, arc_pkg::USE_FREF2, arc_pkg::USE_FCORR};
  endfunction

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_voltage_unit_hz   <= 1'b0;
      o_universal_unit_hz <= 1'b0;
    end else begin
      o_voltage_unit_hz   <= unit_hz(use_sel[0], i_correction_multiplicative);
      o_universal_unit_hz <= unit_hz(use_sel[1], i_correction_multiplicative);
    end
  end

  for (genvar u = 0; u < arc_pkg::NUM_USES; u++) begin : g_use
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
        o_use_value[u] <= '0;
        o_use_valid[u] <= 1'b0;
      end else if (use_sel[0] == USE_CODES[u]) begin
        o_use_value[u] <= acc[0][31:arc_pkg::FRAC_W];
        o_use_valid[u] <= 1'b1;
      end else if (use_sel[1] == USE_CODES[u]) begin
        o_use_value[u] <= acc[1][31:arc_pkg::FRAC_W];
        o_use_valid[u] <= 1'b1;
      end else begin
        o_use_value[u] <= '0;
        o_use_valid[u] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status, interrupt and read-back
  logic [arc_pkg::ST_W-1:0] st_set;
  logic                     st_rd;
  assign st_set = {loss && loss_react == arc_pkg::REACT_TRIP, loss, (wr_vcfg || wr_ucfg) && conflict};
  assign st_rd  = i_rd && (i_addr == arc_pkg::ADDR_STATUS);

  // Set beats the clear of a status read in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      status <= '0;
    end else begin
      status <= (st_rd ? '0 : status) | st_set;
    end
  end

  assign o_irq = |(status & mask);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        arc_pkg::ADDR_VOLT_CFG:    o_rdata <= {21'h0, range_sel[0], 4'h0, use_sel[0]};
        arc_pkg::ADDR_VOLT_LOW:    o_rdata <= {16'h0, low_pt[0]};
        arc_pkg::ADDR_VOLT_HIGH:   o_rdata <= {16'h0, high_pt[0]};
        arc_pkg::ADDR_VOLT_SMOOTH: o_rdata <= {16'h0, smooth[0]};
        arc_pkg::ADDR_UNIV_CFG:    o_rdata <= {14'h0, loss_react, 5'h0, range_sel[1], 4'h0, use_sel[1]};
        arc_pkg::ADDR_UNIV_LOW:    o_rdata <= {16'h0, low_pt[1]};
        arc_pkg::ADDR_UNIV_HIGH:   o_rdata <= {16'h0, high_pt[1]};
        arc_pkg::ADDR_UNIV_SMOOTH: o_rdata <= {16'h0, smooth[1]};
        arc_pkg::ADDR_EMERG:       o_rdata <= {16'h0, emerg_val};
        arc_pkg::ADDR_STATUS:      o_rdata <= {29'h0, status};
        arc_pkg::ADDR_MASK:        o_rdata <= {29'h0, mask};
        arc_pkg::ADDR_FAULT_ACK:   o_rdata <= {31'h0, trip_latch};
        arc_pkg::ADDR_VOLT_VALUE:  o_rdata <= {16'h0, acc[0][31:arc_pkg::FRAC_W]};
        arc_pkg::ADDR_UNIV_VALUE:  o_rdata <= {16'h0, acc[1][31:arc_pkg::FRAC_W]};
        default:                   o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
endmodule

/* File: verilog/arc_pkg.sv */
// Constants for analog reference input conditioning.
// Assumes a 16-bit signed converter sample where code FULL_CODE is +10 V or 20 mA.
package arc_pkg;
  localparam int VAL_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_VOLT_CFG    = 8'h00;
  localparam logic [7:0] ADDR_VOLT_LOW    = 8'h04;
  localparam logic [7:0] ADDR_VOLT_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_VOLT_SMOOTH = 8'h0C;
  localparam logic [7:0] ADDR_UNIV_CFG    = 8'h10;
  localparam logic [7:0] ADDR_UNIV_LOW    = 8'h14;
  localparam logic [7:0] ADDR_UNIV_HIGH   = 8'h18;
  localparam logic [7:0] ADDR_UNIV_SMOOTH = 8'h1C;
  localparam logic [7:0] ADDR_EMERG       = 8'h20;
  localparam logic [7:0] ADDR_STATUS      = 8'h24;
  localparam logic [7:0] ADDR_MASK        = 8'h28;
  localparam logic [7:0] ADDR_FAULT_ACK   = 8'h2C;
  localparam logic [7:0] ADDR_VOLT_VALUE  = 8'h30;
  localparam logic [7:0] ADDR_UNIV_VALUE  = 8'h34;

  // Config field positions
  localparam int USE_LSB   = 0;
  localparam int RANGE_LSB = 8;
  localparam int REACT_LSB = 16;

  // Use codes
  localparam logic [3:0] USE_NONE   = 4'h0;
  localparam logic [3:0] USE_FREF1  = 4'h1;
  localparam logic [3:0] USE_FREF2  = 4'h2;
  localparam logic [3:0] USE_FCORR  = 4'h3;
  localparam logic [3:0] USE_PIDSET = 4'h6;
  localparam logic [3:0] USE_PIDFB  = 4'h7;
  localparam logic [3:0] USE_REQ    = 4'hF;
  localparam int         NUM_USES   = 6;

  // Range codes
  localparam logic [2:0] RANGE_0_10V = 3'h1;
  localparam logic [2:0] RANGE_PM10V = 3'h2;
  localparam logic [2:0] RANGE_0_20MA = 3'h3;
  localparam logic [2:0] RANGE_4_20MA = 3'h4;

  // Loss reactions
  localparam logic [1:0] REACT_TRIP = 2'h1;
  localparam logic [1:0] REACT_HOLD = 2'h2;
  localparam logic [1:0] REACT_EMERG = 2'h3;

  // Converter codes: full scale, live zero (4 mA) and loss threshold (2 mA)
  localparam logic signed [16:0] FULL_CODE = 17'sh07FFF;
  localparam logic signed [16:0] ZERO4_CODE = 17'sh01999;
  localparam logic signed [16:0] LOSS_CODE = 17'sh00CCC;

  // Values in 0.1 Hz or 0.1 % steps; smoothing time in 0.1 s steps
  localparam logic [15:0] HIGH_RESET   = 16'h01F4;
  localparam logic [15:0] SMOOTH_MAX   = 16'h012C;
  localparam logic [15:0] SMOOTH_RESET = 16'h0001;
  localparam int          FRAC_W       = 16;

  // Status bits
  localparam int ST_MULTI = 0;
  localparam int ST_LOSS  = 1;
  localparam int ST_TRIP  = 2;
  localparam int ST_W     = 3;
endpackage

/* File: verif/arc_src_model.sv */
// Source model: two converter channels that deliver one sample pair per strobe.
// Assumes the bench asks for a sample pair with a one-cycle request pulse.
`timescale 1ns/1ns
module arc_src_model (
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  input  wire logic               i_req,
  input  wire logic signed [15:0] i_volt,
  input  wire logic signed [15:0] i_univ,
  output logic                    o_sample_strobe,
  output logic signed [15:0]      o_voltage_sample,
  output logic signed [15:0]      o_universal_sample
);
  ////////////////////////////////////////////////////////////////////////////////
  // Lines carry inverted data between strobes, so sampling off the strobe shows up
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sample_strobe    <= 1'b0;
      o_voltage_sample   <= 16'h0000;
      o_universal_sample <= 16'h0000;
    end else if (i_req) begin
      o_sample_strobe    <= 1'b1;
      o_voltage_sample   <= i_volt;
      o_universal_sample <= i_univ;
    end else begin
      o_sample_strobe    <= 1'b0;
      o_voltage_sample   <= ~o_voltage_sample;
      o_universal_sample <= ~o_universal_sample;
    end
  end
endmodule

/* File: verif/arc_input_cond_checker.sv */
// Checker: port-level timing relations of the reference conditioning block.
// Assumes it is bound to arc_input_cond and sees only its ports.
`timescale 1ns/1ns
module arc_input_cond_checker (
  input wire logic                               i_sys_clk,
  input wire logic                               i_reset,
  input wire logic [arc_pkg::ADDR_W-1:0]         i_addr,
  input wire logic [arc_pkg::DATA_W-1:0]         i_wdata,
  input wire logic                               i_wr,
  input wire logic                               i_rd,
  input wire logic [arc_pkg::DATA_W-1:0]         o_rdata,
  input wire logic signed [15:0]                 i_voltage_sample,
  input wire logic signed [15:0]                 i_universal_sample,
  input wire logic                               i_sample_strobe,
  input wire logic                               i_correction_multiplicative,
  input wire logic [arc_pkg::NUM_USES-1:0][15:0] o_use_value,
  input wire logic [arc_pkg::NUM_USES-1:0]       o_use_valid,
  input wire logic                               o_voltage_unit_hz,
  input wire logic                               o_universal_unit_hz,
  input wire logic                               o_ref_loss,
  input wire logic                               o_alarm,
  input wire logic                               o_trip,
  input wire logic                               o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////////
  trip_after_loss_a: assert property (
    $rose(o_trip) |-> $past(o_ref_loss)) else $error("trip rose without loss");
  alarm_needs_loss_a: assert property (
    o_alarm |-> o_ref_loss) else $error("alarm without loss");
  loss_rise_a: assert property (
    $rose(o_ref_loss) |-> $past(i_sample_strobe) && $past(i_universal_sample) < arc_pkg::LOSS_CODE)
    else $error("loss without low sample");
  loss_update_a: assert property (
    $changed(o_ref_loss) |-> $past(i_sample_strobe) || $past(i_wr, 2)) else $error("loss moved off sample");
  trip_clear_a: assert property (
    $fell(o_trip) |-> $past(i_wr && i_addr == arc_pkg::ADDR_FAULT_ACK) && !$past(o_ref_loss))
    else $error("trip cleared without ack");
  use_valid_a: assert property (
    $changed(o_use_valid) |-> $past(i_wr, 2) || $past(i_reset, 2)) else $error("use valid moved without write");
  value_timing_a: assert property (
    $changed(o_use_value) |-> $past(i_sample_strobe, 2) || $past(i_wr) || $past(i_wr, 2))
    else $error("use value moved off sample");
  unit_flag_a: assert property (
    $changed(o_universal_unit_hz) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_reset, 2)
      || $past(i_correction_multiplicative) != $past(i_correction_multiplicative, 2))
    else $error("unit moved without cause");
endmodule

bind arc_input_cond arc_input_cond_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_voltage_sample(i_voltage_sample), .i_universal_sample(i_universal_sample),
  .i_sample_strobe(i_sample_strobe), .i_correction_multiplicative(i_correction_multiplicative),
  .o_use_value(o_use_value), .o_use_valid(o_use_valid), .o_voltage_unit_hz(o_voltage_unit_hz),
  .o_universal_unit_hz(o_universal_unit_hz), .o_ref_loss(o_ref_loss), .o_alarm(o_alarm),
  .o_trip(o_trip), .o_irq(o_irq));

/* File: verif/arc_input_cond_tb_top.sv */
// Testbench: register bus, use distribution, scaling, loss reactions and smoothing.
// Assumes SAMPLE_US=100000 so one smoothing step equals one sample.
`timescale 1ns/1ns
module arc_input_cond_tb_top;
  logic              i_sys_clk, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_corr = 1'b0, req = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0, d;
  logic signed [15:0] vreq = 16'h0000, ureq = 16'h0000, vs, us, lo, hi, em;
  logic              strobe, uhz, vhz, loss, alarm, trip, irq;
  logic [5:0][15:0]  uv;
  logic [5:0]        uvld;
  int                error_cnt = 0, n_checks = 0, cyc = 0;
  real               diff;
  logic [3:0]  codes [7] = '{arc_pkg::USE_NONE, arc_pkg::USE_FREF1, arc_pkg::USE_FREF2,
    arc_pkg::USE_FCORR, arc_pkg::USE_PIDSET, arc_pkg::USE_PIDFB, arc_pkg::USE_REQ};
  logic [7:0]  dfl_a [7] = '{arc_pkg::ADDR_UNIV_CFG, arc_pkg::ADDR_VOLT_CFG, arc_pkg::ADDR_UNIV_HIGH,
    arc_pkg::ADDR_UNIV_SMOOTH, arc_pkg::ADDR_VOLT_SMOOTH, arc_pkg::ADDR_MASK, 8'h3C};
  logic [31:0] dfl_v [7] = '{32'h00010401, 32'h00000100, 32'h000001F4, 32'h1, 32'h1, 32'h0, 32'h0};

  arc_src_model src (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(req), .i_volt(vreq),
    .i_univ(ureq), .o_sample_strobe(strobe), .o_voltage_sample(vs), .o_universal_sample(us));
  arc_input_cond #(.SAMPLE_US(100000)) dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(addr),
    .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(d), .i_voltage_sample(vs),
    .i_universal_sample(us), .i_sample_strobe(strobe), .i_correction_multiplicative(i_corr),
    .o_use_value(uv), .o_use_valid(uvld), .o_voltage_unit_hz(vhz), .o_universal_unit_hz(uhz),
    .o_ref_loss(loss), .o_alarm(alarm), .o_trip(trip), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ucfg(logic [3:0] u, logic [2:0] r, logic [1:0] x);
    return {14'h0000, x, 5'h00, r, 4'h0, u};
  endfunction
  // First-order step response from lo towards hi after k samples
  function automatic real filt(real l, real h, int n, int k);
    return h - (h - l) * ((1.0 - 1.0 / n) ** k);
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr  <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] q);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 q = d;
  endtask
  task automatic smp(logic signed [15:0] v, logic signed [15:0] u);
    @(posedge i_sys_clk);
    req  <= 1'b1;
    vreq <= v;
    ureq <= u;
    @(posedge i_sys_clk);
    req <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // Whole run is well under 2000 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin : main
    logic [31:0] q;
    q = $urandom(27200);
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(dfl_a[i], q);
      chk("default", q, dfl_v[i]);
    end
    chk("valid after reset", {26'h0, uvld}, 32'h1);
    wr(arc_pkg::ADDR_UNIV_SMOOTH, 32'h0);
    for (int i = 0; i < 7; i++) begin
      lo = 16'($urandom_range(6000)) - 16'd3000;
      hi = 16'($urandom_range(6000)) - 16'd3000;
      wr(arc_pkg::ADDR_UNIV_LOW, {16'h0000, lo});
      wr(arc_pkg::ADDR_UNIV_HIGH, {16'h0000, hi});
      wr(arc_pkg::ADDR_UNIV_CFG, ucfg(codes[i], arc_pkg::RANGE_4_20MA, arc_pkg::REACT_TRIP));
      smp(16'h0000, arc_pkg::FULL_CODE[15:0]);
      if (i == 0) chk("none valid", {26'h0, uvld}, 32'h0);
      else begin
        chk("full scale", {16'h0, uv[i-1]}, {16'h0, hi});
        chk("unit", {31'h0, uhz}, {31'h0, i < 4});
        smp(16'h0000, arc_pkg::ZERO4_CODE[15:0]);
        chk("live zero", {16'h0, uv[i-1]}, {16'h0, lo});
      end
    end
    wr(arc_pkg::ADDR_UNIV_CFG, ucfg(arc_pkg::USE_FCORR, arc_pkg::RANGE_4_20MA, arc_pkg::REACT_TRIP));
    @(posedge i_sys_clk);
    i_corr <= 1'b1;
    smp(16'h0000, arc_pkg::FULL_CODE[15:0]);
    chk("mult unit", {31'h0, uhz}, 32'h0);
    chk("mult value", {16'h0, uv[2]}, {16'h0, hi});
    @(posedge i_sys_clk);
    i_corr <= 1'b0;
    wr(arc_pkg::ADDR_UNIV_CFG, ucfg(arc_pkg::USE_FREF1, arc_pkg::RANGE_4_20MA, arc_pkg::REACT_TRIP));
    wr(arc_pkg::ADDR_VOLT_SMOOTH, 32'h0);
    for (int r = 1; r < 3; r++) begin
      lo = 16'($urandom_range(6000)) - 16'd3000;
      hi = 16'($urandom_range(6000)) - 16'd3000;
      wr(arc_pkg::ADDR_VOLT_LOW, {16'h0000, lo});
      wr(arc_pkg::ADDR_VOLT_HIGH, {16'h0000, hi});
      wr(arc_pkg::ADDR_VOLT_CFG, {21'h0, 3'(r), 4'h0, arc_pkg::USE_FREF2});
      smp(r == 1 ? 16'h0000 : 16'h8001, arc_pkg::ZERO4_CODE[15:0]);
      chk("volt bottom", {16'h0, uv[1]}, {16'h0, lo});
      smp(16'h7FFF, arc_pkg::ZERO4_CODE[15:0]);
      chk("volt top", {16'h0, uv[1]}, {16'h0, hi});
      chk("volt unit", {31'h0, vhz}, 32'h1);
    end
    // Second claim on the universal input's use, first with the interrupt masked
    wr(arc_pkg::ADDR_VOLT_CFG, 32'h00000201);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(arc_pkg::ADDR_VOLT_CFG, q);
    chk("refused use", q, 32'h00000202);
    rd(arc_pkg::ADDR_STATUS, q);
    chk("multi status", q & 32'h1, 32'h1);
    wr(arc_pkg::ADDR_MASK, 32'h1);
    wr(arc_pkg::ADDR_VOLT_CFG, 32'h00000201);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd(arc_pkg::ADDR_STATUS, q);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(arc_pkg::ADDR_UNIV_LOW, 32'h0);
    wr(arc_pkg::ADDR_UNIV_HIGH, 32'h1F4);
    em = 16'($urandom_range(6000)) - 16'd3000;
    wr(arc_pkg::ADDR_EMERG, {16'h0000, em});
    smp(16'h0000, arc_pkg::LOSS_CODE[15:0] - 16'h0008);
    chk("loss trip", {29'h0, loss, trip, alarm}, 32'h6);
    rd(arc_pkg::ADDR_STATUS, q);
    chk("loss status", q & 32'h6, 32'h6);
    wr(arc_pkg::ADDR_FAULT_ACK, 32'h0);
    chk("ack under loss", {31'h0, trip}, 32'h1);
    smp(16'h0000, arc_pkg::ZERO4_CODE[15:0]);
    wr(arc_pkg::ADDR_FAULT_ACK, 32'h0);
    chk("ack clears", {30'h0, loss, trip}, 32'h0);
    for (int x = 2; x < 4; x++) begin
      wr(arc_pkg::ADDR_UNIV_CFG, ucfg(arc_pkg::USE_FREF1, arc_pkg::RANGE_4_20MA, 2'(x)));
      smp(16'h0000, arc_pkg::FULL_CODE[15:0]);
      smp(16'h0000, arc_pkg::LOSS_CODE[15:0] - 16'h0008);
      chk("alarm no trip", {30'h0, alarm, trip}, 32'h2);
      chk("loss value", {16'h0, uv[0]}, {16'h0, x == 2 ? 16'h01F4 : em});
      smp(16'h0000, arc_pkg::ZERO4_CODE[15:0]);
    end
    wr(arc_pkg::ADDR_UNIV_CFG, ucfg(arc_pkg::USE_FREF1, arc_pkg::RANGE_4_20MA, arc_pkg::REACT_TRIP));
    wr(arc_pkg::ADDR_UNIV_SMOOTH, 32'h3E8);
    rd(arc_pkg::ADDR_UNIV_SMOOTH, q);
    chk("smoothing clamp", q, 32'h12C);
    wr(arc_pkg::ADDR_UNIV_SMOOTH, 32'h4);
    for (int k = 1; k < 5; k++) begin
      smp(16'h0000, arc_pkg::FULL_CODE[15:0]);
      diff = $itor($signed(uv[0])) - filt(0.0, 500.0, 4, k);
      chk("smoothing step", {31'h0, diff < 4.0 && diff > -4.0}, 32'h1);
    end
    // Below the loss level, but supervision is off outside the live-zero range
    wr(arc_pkg::ADDR_UNIV_CFG, ucfg(arc_pkg::USE_FREF1, arc_pkg::RANGE_0_20MA, arc_pkg::REACT_TRIP));
    smp(16'h0000, 16'h0100);
    chk("no loss 0-20", {30'h0, loss, trip}, 32'h0);
    test_done();
  end
endmodule
